// file: common/swc_pkg.sv
// constants and types for the switch control register block
// Contract
// - sink bits 1:0 pick the source: 00 one, 01 two, 10 three, 11 four
// - sink bits 7:5 are reserved and change nothing
// - sink bit 4 sets the output drive mode, de-emphasis or not
// - sink bit 3 turns the sink control-bus buffer on or to high impedance
// - sink bit 2 drives or floats that sink's video pair
// - source register read shows each source's +5 V presence
// - source bit 5 picks the main display: 0 sink one, 1 sink two
// - source bit 4 set makes each video output follow its source presence
// - source bits 3:0 at 0 float that source buffer and video selecting it
// - device acknowledges matching address, sub-address and data bytes
// - one byte per transaction, no sub-address auto-increment
// - sub-address bits 7:2 are zero, bits 1:0 select the register
// - address bits 2:1 match the select pins, bits 7:3 fixed prefix
// - every byte travels most significant bit first
// - sub-address 1 sink one, 2 sink two, 3 source register
// - every register powers up at 0000 0011
// - sink bit 2 at 0 drives the video, at 1 floats it
package swc_pkg;
    localparam logic [1:0] SWC_SUB_SINK1 = 2'h1;
    localparam logic [1:0] SWC_SUB_SINK2 = 2'h2;
    localparam logic [1:0] SWC_SUB_SOURCE = 2'h3;
    localparam logic [7:0] SWC_REG_RESET = 8'h03;
    localparam logic [1:0] SWC_PTR_RESET = 2'h0;
    localparam logic [4:0] SWC_ADDR_PREFIX = 5'h0B;
    localparam int SWC_SEL_LSB = 0;
    localparam int SWC_VIDEO_OFF_BIT = 2;
    localparam int SWC_BUF_ON_BIT = 3;
    localparam int SWC_DEEMPH_BIT = 4;
    localparam int SWC_GATE_BIT = 4;
    localparam int SWC_PRIO_BIT = 5;
    localparam logic [3:0] SWC_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] SWC_RD_LAST_BIT = 4'h7;

    typedef enum logic [3:0] {
        SWC_IDLE = 4'h0,
        SWC_ADDR = 4'h1,
        SWC_AACK = 4'h3,
        SWC_SUB = 4'h2,
        SWC_SACK = 4'h6,
        SWC_DATA = 4'h7,
        SWC_DACK = 4'h5,
        SWC_RD = 4'h4,
        SWC_WAIT = 4'hC
    } swc_state_t;
endpackage : swc_pkg

// file: rtl/swc_i2c_slave.sv
// serial control-bus slave: one-byte write and read with a sub-address pointer
`timescale 1ns/1ps
`default_nettype none
module swc_i2c_slave
    import swc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    // bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // address select pins
    input wire logic i_addr_select_hi,
    input wire logic i_addr_select_lo,
    // register side
    input wire logic [7:0] i_rd_data,
    output logic [1:0] o_ptr,
    output logic [7:0] o_wr_data,
    output logic o_wr_en
);
    swc_state_t state_q, state_d;
    logic scl_q, sda_q;
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic [1:0] ptr_q;
    logic rw_q;
    logic wr_en_q;

    wire scl_rise = i_scl & ~scl_q;
    wire scl_fall = ~i_scl & scl_q;
    wire start_seen = i_scl & scl_q & sda_q & ~i_sda;
    wire stop_seen = i_scl & scl_q & ~sda_q & i_sda;
    wire byte_done = scl_fall & (cnt_q == SWC_BITS_PER_BYTE);
    wire addr_match = (sh_q[7:3] == SWC_ADDR_PREFIX)
        & (sh_q[2:1] == {i_addr_select_hi, i_addr_select_lo});
    wire sub_ok = (sh_q[7:2] == 6'h00);
    wire in_ack = (state_q == SWC_AACK) | (state_q == SWC_SACK) | (state_q == SWC_DACK);
    wire shifting = (state_q == SWC_ADDR) | (state_q == SWC_SUB) | (state_q == SWC_DATA);

    // next state; start and stop win over everything else
    always_comb begin
        state_d = state_q;
        if (start_seen) begin
            state_d = SWC_ADDR;
        end else if (stop_seen) begin
            state_d = SWC_IDLE;
        end else begin
            case (state_q)
                SWC_ADDR: if (byte_done) state_d = addr_match ? SWC_AACK : SWC_WAIT;
                SWC_AACK: if (scl_fall) state_d = rw_q ? SWC_RD : SWC_SUB;
                SWC_SUB: if (byte_done) state_d = sub_ok ? SWC_SACK : SWC_WAIT;
                SWC_SACK: if (scl_fall) state_d = SWC_DATA;
                SWC_DATA: if (byte_done) state_d = SWC_DACK;
                // further bytes get no acknowledge
                SWC_DACK: if (scl_fall) state_d = SWC_WAIT;
                SWC_RD: if (scl_fall && cnt_q == SWC_RD_LAST_BIT) state_d = SWC_WAIT;
                default: state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= SWC_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= SWC_PTR_RESET;
            rw_q <= 1'b0;
            wr_en_q <= 1'b0;
        end else if (i_ce) begin
            state_q <= state_d;
            scl_q <= i_scl;
            sda_q <= i_sda;
            wr_en_q <= (state_q == SWC_DATA) & byte_done & ~stop_seen & ~start_seen;
            if (start_seen || in_ack) begin
                cnt_q <= (in_ack && scl_fall) ? 4'h0 : cnt_q;
            end
            if (start_seen) begin
                cnt_q <= 4'h0;
            end else if (shifting && scl_rise) begin
                sh_q <= {sh_q[6:0], i_sda};
                cnt_q <= cnt_q + 4'h1;
            end else if (state_q == SWC_AACK && scl_fall) begin
                sh_q <= i_rd_data;
                cnt_q <= 4'h0;
            end else if (state_q == SWC_RD && scl_fall) begin
                sh_q <= {sh_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
            end
            if (state_q == SWC_ADDR && byte_done) begin
                rw_q <= sh_q[0];
            end
            // pointer persists so a later read returns this register
            if (state_q == SWC_SUB && byte_done && sub_ok) begin
                ptr_q <= sh_q[1:0];
            end
        end
    end

    assign o_sda_oe = in_ack | ((state_q == SWC_RD) & ~sh_q[7]);
    assign o_ptr = ptr_q;
    assign o_wr_data = sh_q;
    assign o_wr_en = wr_en_q & i_ce;
endmodule : swc_i2c_slave
`default_nettype wire

// file: rtl/swc_regs.sv
// switch control registers with sink routing and output enables
`timescale 1ns/1ps
`default_nettype none
module swc_regs
    import swc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    // control bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    input wire logic i_addr_select_hi,
    input wire logic i_addr_select_lo,
    // source presence and output enable pin
    input wire logic i_source1_presence,
    input wire logic i_source2_presence,
    input wire logic i_source3_presence,
    input wire logic i_source4_presence,
    input wire logic i_oe_n,
    // sink one controls
    output logic [1:0] o_sink1_src_sel,
    output logic o_sink1_deemph_select,
    output logic o_sink1_ctrl_bus_buffer_on,
    output logic o_sink1_video_on,
    // sink two controls
    output logic [1:0] o_sink2_src_sel,
    output logic o_sink2_deemph_select,
    output logic o_sink2_ctrl_bus_buffer_on,
    output logic o_sink2_video_on,
    // source side controls
    output logic [3:0] o_source_buffer_on,
    output logic o_main_is_sink2
);
    logic [7:0] sink1_q, sink2_q, source_q;
    logic [1:0] sel1_q, sel2_q;
    logic de1_q, de2_q, buf1_q, buf2_q, vid1_q, vid2_q;
    logic [3:0] srcbuf_q;
    logic main2_q;
    logic [1:0] ptr;
    logic [7:0] wr_data;
    logic wr_en;
    logic [7:0] rd_data;

    wire [3:0] presence = {i_source4_presence, i_source3_presence,
        i_source2_presence, i_source1_presence};
    wire gate_on = source_q[SWC_GATE_BIT];

    // one function for both sinks keeps their gating identical
    function automatic logic video_on(input logic [7:0] ctl, input logic [3:0] en,
        input logic gate, input logic [3:0] pres, input logic oe_n);
        logic [1:0] sel;
        sel = ctl[SWC_SEL_LSB +: 2];
        video_on = ~ctl[SWC_VIDEO_OFF_BIT]
            & en[sel] & ~oe_n
            & (~gate | pres[sel]);
    endfunction : video_on

    wire vid1_d = video_on(sink1_q, source_q[3:0], gate_on, presence, i_oe_n);
    wire vid2_d = video_on(sink2_q, source_q[3:0], gate_on, presence, i_oe_n);

    // low bits show live presence, the stored enables are write-only
    assign rd_data = (ptr == SWC_SUB_SINK1) ? sink1_q :
        (ptr == SWC_SUB_SINK2) ? sink2_q :
        (ptr == SWC_SUB_SOURCE) ? {2'h0, source_q[5:4], presence} : 8'h00;

    swc_i2c_slave u_slave (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .i_addr_select_hi(i_addr_select_hi),
        .i_addr_select_lo(i_addr_select_lo),
        .i_rd_data(rd_data),
        .o_ptr(ptr),
        .o_wr_data(wr_data),
        .o_wr_en(wr_en)
    );

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sink1_q <= SWC_REG_RESET;
            sink2_q <= SWC_REG_RESET;
            source_q <= SWC_REG_RESET;
        end else if (wr_en) begin
            // sink reserved bits are kept for read-back only; source bits 7:6 are cleared
            if (ptr == SWC_SUB_SINK1) sink1_q <= wr_data;
            if (ptr == SWC_SUB_SINK2) sink2_q <= wr_data;
            if (ptr == SWC_SUB_SOURCE) source_q <= {2'h0, wr_data[5:0]};
        end
    end

    // outputs from flops; one cycle behind the registers and pins
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sel1_q <= 2'h0;
            sel2_q <= 2'h0;
            de1_q <= 1'b0;
            de2_q <= 1'b0;
            buf1_q <= 1'b0;
            buf2_q <= 1'b0;
            vid1_q <= 1'b0;
            vid2_q <= 1'b0;
            srcbuf_q <= 4'h0;
            main2_q <= 1'b0;
        end else if (i_ce) begin
            sel1_q <= sink1_q[SWC_SEL_LSB +: 2];
            sel2_q <= sink2_q[SWC_SEL_LSB +: 2];
            de1_q <= sink1_q[SWC_DEEMPH_BIT];
            de2_q <= sink2_q[SWC_DEEMPH_BIT];
            buf1_q <= sink1_q[SWC_BUF_ON_BIT];
            buf2_q <= sink2_q[SWC_BUF_ON_BIT];
            vid1_q <= vid1_d;
            vid2_q <= vid2_d;
            srcbuf_q <= source_q[3:0];
            main2_q <= source_q[SWC_PRIO_BIT];
        end
    end

    assign o_sink1_src_sel = sel1_q;
    assign o_sink2_src_sel = sel2_q;
    assign o_sink1_deemph_select = de1_q;
    assign o_sink2_deemph_select = de2_q;
    assign o_sink1_ctrl_bus_buffer_on = buf1_q;
    assign o_sink2_ctrl_bus_buffer_on = buf2_q;
    assign o_sink1_video_on = vid1_q;
    assign o_sink2_video_on = vid2_q;
    assign o_source_buffer_on = srcbuf_q;
    assign o_main_is_sink2 = main2_q;

    // checks; sampled reset in antecedents keeps the release edge from misfiring
    property p_sel;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && i_reset_n) |=> o_sink1_src_sel == $past(sink1_q[1:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("sink one source select lag");

    property p_vid_off;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && sink2_q[SWC_VIDEO_OFF_BIT]) |=> !o_sink2_video_on;
    endproperty
    a_vid_off: assert property (p_vid_off) else $error("video driven while off");

    property p_buf;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && i_reset_n) |=> o_sink1_ctrl_bus_buffer_on == $past(sink1_q[SWC_BUF_ON_BIT]);
    endproperty
    a_buf: assert property (p_buf) else $error("sink buffer mismatch");

    property p_deemph;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && i_reset_n) |=> o_sink2_deemph_select == $past(sink2_q[SWC_DEEMPH_BIT]);
    endproperty
    a_deemph: assert property (p_deemph) else $error("de-emphasis mismatch");

    property p_src_en;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && !source_q[sink1_q[1:0]]) |=> !o_sink1_video_on;
    endproperty
    a_src_en: assert property (p_src_en) else $error("disabled source drives video");

    property p_gate;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && gate_on && !presence[sink2_q[1:0]]) |=> !o_sink2_video_on;
    endproperty
    a_gate: assert property (p_gate) else $error("video on without presence");

    property p_vid_on;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && !gate_on && !i_oe_n && !sink1_q[2] && source_q[sink1_q[1:0]])
            |=> o_sink1_video_on;
    endproperty
    a_vid_on: assert property (p_vid_on) else $error("video not driven");

    property p_prio;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_ce && i_reset_n) |=> o_main_is_sink2 == $past(source_q[SWC_PRIO_BIT]);
    endproperty
    a_prio: assert property (p_prio) else $error("main display mismatch");

    property p_write;
        @(posedge i_clk) disable iff (!i_reset_n)
        (wr_en && ptr == SWC_SUB_SINK2) |=> sink2_q == $past(wr_data);
    endproperty
    a_write: assert property (p_write) else $error("sink two write lost");

    property p_reset;
        @(posedge i_clk) $rose(i_reset_n) |-> (sink1_q == SWC_REG_RESET)
            && (source_q == SWC_REG_RESET);
    endproperty
    a_reset: assert property (p_reset) else $error("bad power-up value");

    c_write1: cover property (@(posedge i_clk) wr_en && ptr == SWC_SUB_SINK1);
    c_write3: cover property (@(posedge i_clk) wr_en && ptr == SWC_SUB_SOURCE);
    c_both_on: cover property (@(posedge i_clk) o_sink1_video_on && o_sink2_video_on);
    c_read: cover property (@(posedge i_clk) o_sda_oe && !i_scl);
endmodule : swc_regs
`default_nettype wire

// file: verif/swc_i2c_master.sv
// control-bus master model: start, stop, byte transfers, register write and read
`timescale 1ns/1ps
`default_nettype none
module swc_i2c_master (
    // clock
    input wire logic i_clk,
    // bus lines, data seen as the resolved wire
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // data moves two clocks clear of either clock edge
    task automatic bit_xfer(input logic b, output logic got);
        o_sda <= b;
        tick(2);
        o_scl <= 1'b1;
        tick(2);
        got = i_sda;
        tick(2);
        o_scl <= 1'b0;
        tick(2);
    endtask : bit_xfer

    task automatic start_cond;
        o_sda <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(3);
        o_sda <= 1'b0;
        tick(3);
        o_scl <= 1'b0;
        tick(2);
    endtask : start_cond

    task automatic stop_cond;
        o_sda <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(3);
        o_sda <= 1'b1;
        tick(3);
    endtask : stop_cond

    // ack slot always released: a read byte therefore ends in a nack
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(tx[i], rx[i]);
        end
        bit_xfer(1'b1, ack);
    endtask : xfer

    task automatic write_reg(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] dat,
        output logic [2:0] acks);
        logic [7:0] rx;
        start_cond;
        xfer(adr, rx, acks[2]);
        xfer(sub, rx, acks[1]);
        xfer(dat, rx, acks[0]);
        stop_cond;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] adr, input logic [7:0] sub, output logic [7:0] dat,
        output logic [2:0] acks);
        logic nack;
        start_cond;
        xfer(adr, dat, acks[2]);
        xfer(sub, dat, acks[1]);
        stop_cond;
        start_cond;
        xfer(adr | 8'h01, dat, acks[0]);
        xfer(8'hFF, dat, nack);
        stop_cond;
    endtask : read_reg
endmodule : swc_i2c_master
`default_nettype wire

// file: verif/swc_regs_test.sv
// self-checking bench for the switch control registers
`timescale 1ns/1ps
`default_nettype none
module swc_regs_test import swc_pkg::*; ();
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic a_hi = 1'b0;
    logic a_lo = 1'b0;
    logic oe_n = 1'b0;
    logic [3:0] pres = 4'h0;
    logic [7:0] m_s1 = 8'h03;
    logic [7:0] m_s2 = 8'h03;
    logic [5:0] m_src = 6'h03;
    logic [31:0] seed = 32'hF14C80EE;
    int miscompares = 0;
    int cmp_count = 0;
    wire logic scl, m_sda, sda_oe, s1_de, s1_buf, s1_vid, s2_de, s2_buf, s2_vid, main2;
    wire logic [1:0] s1_sel, s2_sel;
    wire logic [3:0] src_buf;
    // open drain with pull-up: low if either party pulls
    wire logic sda_line = m_sda & ~sda_oe;

    always #10 i_clk = ~i_clk;

    swc_regs swc_regs_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
        .i_scl(scl), .i_sda(sda_line), .o_sda_oe(sda_oe),
        .i_addr_select_hi(a_hi), .i_addr_select_lo(a_lo),
        .i_source1_presence(pres[0]), .i_source2_presence(pres[1]),
        .i_source3_presence(pres[2]), .i_source4_presence(pres[3]), .i_oe_n(oe_n),
        .o_sink1_src_sel(s1_sel), .o_sink1_deemph_select(s1_de),
        .o_sink1_ctrl_bus_buffer_on(s1_buf), .o_sink1_video_on(s1_vid),
        .o_sink2_src_sel(s2_sel), .o_sink2_deemph_select(s2_de),
        .o_sink2_ctrl_bus_buffer_on(s2_buf), .o_sink2_video_on(s2_vid),
        .o_source_buffer_on(src_buf), .o_main_is_sink2(main2));

    swc_i2c_master swc_i2c_master_inst (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl),
        .o_sda(m_sda));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] dev_addr();
        return {SWC_ADDR_PREFIX, a_hi, a_lo, 1'b0};
    endfunction : dev_addr

    // packed as {sel, deemph, buffer, video}; reserved bits 7:5 play no part
    function automatic logic [7:0] exp_sink(input logic [7:0] r);
        logic en;
        en = ~r[2] & m_src[r[1:0]] & ~oe_n & (~m_src[4] | pres[r[1:0]]);
        return {3'h0, r[1:0], r[4], r[3], en};
    endfunction : exp_sink

    function automatic logic [7:0] exp_read(input logic [1:0] s);
        case (s)
            2'h1: return m_s1;
            2'h2: return m_s2;
            2'h3: return {2'h0, m_src[5:4], pres};
            default: return 8'h00;
        endcase
    endfunction : exp_read

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_all;
        check({3'h0, s1_sel, s1_de, s1_buf, s1_vid}, exp_sink(m_s1));
        check({3'h0, s2_sel, s2_de, s2_buf, s2_vid}, exp_sink(m_s2));
        check({3'h0, main2, src_buf}, {3'h0, m_src[5], m_src[3:0]});
    endtask : check_all

    task automatic wr(input logic [7:0] adr, input logic [7:0] sub, input logic [7:0] dat,
        input logic [2:0] exp_acks);
        logic [2:0] acks;
        swc_i2c_master_inst.write_reg(adr, sub, dat, acks);
        check({5'h0, acks}, {5'h0, exp_acks});
        if (exp_acks == 3'b000 && sub == 8'h01) m_s1 = dat;
        if (exp_acks == 3'b000 && sub == 8'h02) m_s2 = dat;
        if (exp_acks == 3'b000 && sub == 8'h03) m_src = dat[5:0];
        tick3();
        check_all;
    endtask : wr

    task automatic tick3;
        repeat (3) @(posedge i_clk);
    endtask : tick3

    task automatic rd_chk(input logic [1:0] sub);
        logic [2:0] acks;
        logic [7:0] got;
        swc_i2c_master_inst.read_reg(dev_addr(), {6'h0, sub}, got, acks);
        check({5'h0, acks}, 8'h00);
        check(got, exp_read(sub));
    endtask : rd_chk

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        tick3();
        check_all;
        for (int s = 1; s < 4; s++) rd_chk(s[1:0]);
        $display("test reset done");
        wr({5'h0A, a_hi, a_lo, 1'b0}, 8'h01, 8'h1C, 3'b111);
        wr({SWC_ADDR_PREFIX, ~a_hi, a_lo, 1'b0}, 8'h01, 8'h1C, 3'b111);
        wr(dev_addr(), 8'h05, 8'hFF, 3'b011);
        $display("test refusals done");
        for (int n = 0; n < 40; n++) begin
            repeat (16) seed = lfsr(seed);
            pres <= seed[3:0];
            oe_n <= seed[4] & seed[5];
            a_hi <= seed[6];
            a_lo <= seed[7];
            @(posedge i_clk);
            wr(dev_addr(), {6'h0, seed[9:8]}, seed[23:16], 3'b000);
            rd_chk(seed[9:8]);
        end
        $display("test random traffic done");
        complete_run();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge i_clk);
        miscompares++;
        complete_run();
    end
endmodule : swc_regs_test
`default_nettype wire
